// ---- rtl/clk_switch_if.sv ----
`timescale 1ns/1ps
interface clk_switch_if;
   logic [1:0] req_sel;
   logic src_prim;
   logic src_sec;
   logic src_int;
   logic clk_level;
   logic [1:0] active_sel;
   logic busy;

   modport ctrl (output req_sel, output src_prim, output src_sec,
      output src_int, input clk_level, input active_sel, input busy);
   modport sw (input req_sel, input src_prim, input src_sec,
      input src_int, output clk_level, output active_sel, output busy);
endinterface

// ---- rtl/clock_select_consts.svh ----
`ifndef CLOCK_SELECT_CONSTS_SVH
`define CLOCK_SELECT_CONSTS_SVH

// Register byte offsets
`define OFS_OSC_CONTROL 12'h000
`define OFS_OSC_CONTROL_TWO 12'h004
`define OFS_CLOCK_CONFIG 12'h008

// First control register fields
`define POS_IDLE_EN 7
`define POS_IFS_LO 4
`define POS_RUN_PRIMARY 3
`define POS_HF_STABLE 2
`define POS_SCS_LO 0

// Second control register fields
`define POS_PLL_RUN 7
`define POS_SEC_RUN 6
`define POS_LFSS 5
`define POS_SPLL_EN 4
`define POS_PRI_DRIVE 2

// Clock configuration register fields
`define POS_FOSC_LO 0
`define POS_CFG_PLL_EN 4
`define POS_PLL_MULT_SEL 5
`define POS_SPLL_MULT 6
`define POS_FAIL 8

// Reset values
`define RST_SCS 2'h0
`define RST_IFS 3'h3
`define RST_PRI_DRIVE 1'h1
`define RST_FOSC 4'h2

// Internal block: code 000 and its divide-by-512 tap
`define IFS_LOW_FREQ 3'h0
`define IFS_FULL_RATE 3'h7
`define DIV512_BIT 8

// Fail monitor: low-frequency edges without a primary edge
`define FAIL_LF_EDGES 4'h4

`endif

// ---- rtl/clock_select_pkg.sv ----
package clock_select_pkg;

   // Primary clock kinds selected by the four-bit configuration field
   typedef enum logic [2:0] {
      KIND_RC, KIND_LP, KIND_XT, KIND_INT, KIND_HS, KIND_EC
   } prim_kind_t;

   typedef enum logic [1:0] {PLL_OFF, PLL_X3, PLL_X4} pll_mode_t;

   typedef enum logic [1:0] {SW_IDLE, SW_WAIT_OLD, SW_WAIT_NEW} sw_state_t;

   // Configuration code to primary kind
   function automatic prim_kind_t prim_kind(input logic [3:0] fosc);
      case (fosc)
         4'h0: prim_kind = KIND_LP;
         4'h1: prim_kind = KIND_XT;
         4'h2, 4'h3: prim_kind = KIND_HS;
         4'h4, 4'h5, 4'h6, 4'h7, 4'hA, 4'hB: prim_kind = KIND_EC;
         4'h8, 4'h9: prim_kind = KIND_INT;
         default: prim_kind = KIND_RC;
      endcase
   endfunction

   // Even codes of RC, EC and internal modes give the quarter-rate output
   function automatic logic pin_is_clkout(input logic [3:0] fosc);
      prim_kind_t k;
      k = prim_kind(fosc);
      pin_is_clkout = (k == KIND_RC || k == KIND_EC || k == KIND_INT) &&
         !fosc[0];
   endfunction

   typedef struct packed {
      sw_state_t state;
      logic [1:0] active;
      logic out;
   } switch_state_t;

   typedef struct packed {
      logic idle_en;
      logic [2:0] ifs;
      logic [1:0] system_clock_select;
      logic lfss;
      logic spll_en;
      logic pri_drive;
      logic [3:0] fosc;
      logic cfg_pll_en;
      logic pll_mult_sel;
      logic spll_mult;
      logic fail;
      logic [3:0] fail_cnt;
      logic [8:0] hf_cnt;
      logic hf_prev;
      logic lf_prev;
      logic prim_prev;
      logic sys_prev;
      logic [1:0] div4;
      logic clk_out;
      logic [31:0] rdata;
      logic slverr;
      logic idle_p;
      logic sleep_p;
      logic wdt_tick;
   } ctrl_state_t;

endpackage

// ---- rtl/clock_switcher.sv ----
`timescale 1ns/1ps
`include "clock_select_consts.svh"
module clock_switcher (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Selection and source levels
   clk_switch_if.sw sw
);
   import clock_select_pkg::*;

   switch_state_t st_reg;
   switch_state_t st_next;

   // Level of a source by select code; 1x is the internal block
   function automatic logic src_level(input logic [1:0] sel,
         input logic p, input logic s, input logic i);
      src_level = sel[1] ? i : (sel[0] ? s : p);
   endfunction

   logic old_lvl;
   logic new_lvl;
   assign old_lvl = src_level(st_reg.active, sw.src_prim, sw.src_sec,
      sw.src_int);
   assign new_lvl = src_level(sw.req_sel, sw.src_prim, sw.src_sec,
      sw.src_int);

   // Break before make: old source is gated off only while low, and the
   // new one opens only while low, so no runt pulse reaches the output
   always_comb begin
      st_next = st_reg;
      case (st_reg.state)
         SW_IDLE: begin
            st_next.out = old_lvl;
            if (sw.req_sel != st_reg.active) begin
               st_next.state = SW_WAIT_OLD; // R3
            end
         end
         SW_WAIT_OLD: begin
            st_next.out = old_lvl;
            if (!old_lvl) begin
               st_next.out = 1'b0; // R21
               st_next.state = SW_WAIT_NEW;
            end
         end
         SW_WAIT_NEW: begin
            st_next.out = 1'b0;
            if (!new_lvl) begin
               st_next.active = sw.req_sel; // R21
               st_next.state = SW_IDLE;
            end
         end
         default: st_next.state = SW_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '{state: SW_IDLE, active: `RST_SCS, out: 1'b0};
      end else begin
         st_reg <= st_next;
      end
   end

   assign sw.clk_level = st_reg.out;
   assign sw.active_sel = st_reg.active;
   assign sw.busy = st_reg.state != SW_IDLE;

   // Output held low throughout the gap between sources
   a_gap_held_low: assert property ( // R21
      @(posedge pclk) disable iff (!presetn)
      st_reg.state == SW_WAIT_NEW |=> !sw.clk_level)
      else $error("clock output not low during switch gap");

   // Switch completes one edge after the new source is seen low
   a_switch_complete: assert property ( // R3
      @(posedge pclk) disable iff (!presetn)
      (st_reg.state == SW_WAIT_NEW && !new_lvl) |=>
      (sw.active_sel == $past(sw.req_sel) && !sw.busy))
      else $error("switch did not complete on low new source");

   c_switch_seen: cover property (
      @(posedge pclk) disable iff (!presetn)
      sw.busy ##1 !sw.busy);
endmodule

// ---- rtl/system_clock_selector.sv ----
`timescale 1ns/1ps
`include "clock_select_consts.svh"
// How it works
// R1: Two-bit select routes one of three sources
// R2: Every reset clears select to primary clock
// R3: Select write switches after short transition
// R4: Three-bit field picks internal block frequency
// R5: Internal frequency write takes effect immediately
// R6: Internal block defaults to 1 MHz
// R7: Code 000 uses low-frequency source select
// R8: Watchdog and monitor always use low oscillator
// R9: Idle enable chooses Sleep or Idle
// R10: PLL multiplier from config and software bits
// R11: PLL off for all other configurations
// R12: PLL input 16 MHz or 8-12 MHz
// R13: Lost external primary falls back internally
// R14: Shared pin gives I/O or quarter clock
// R15: Four-bit config picks one of six sources
// R16: Field positions in both control registers
// R17: Select 1x internal, 01 secondary, 00 primary
// R18: Codes 111..001 give 16 MHz..250 kHz
// R19: Low select 1 divides high oscillator by 512
// R20: Idle enable 1 Idle, 0 Sleep
// R21: Switch without runt pulses or glitches
module system_clock_selector #(
   parameter int FAIL_EDGES = 4
) (
   // APB slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Oscillator levels, sampled on pclk
   input wire logic prim_osc_in,
   input wire logic sec_osc_in,
   input wire logic high_freq_internal_osc,
   input wire logic low_freq_internal_osc,
   input wire logic hf_stable,
   // Power management
   input wire logic sleep_cmd,
   output logic enter_idle,
   output logic enter_sleep,
   // Clock outputs and status
   output logic sys_clk_level,
   output logic [1:0] sys_source,
   output clock_select_pkg::pll_mode_t pll_mode,
   output logic wdt_tick,
   output logic primary_drive_on,
   output logic clock_fail,
   // Shared oscillator pin
   input wire logic gpio_out,
   output logic shared_osc_pin_o,
   output logic shared_osc_pin_oe_n
);
   import clock_select_pkg::*;

   ctrl_state_t st_reg;
   ctrl_state_t st_next;
   clk_switch_if sw_if ();

   prim_kind_t kind;
   logic int_level;
   logic hf_rise;
   logic lf_rise;
   logic prim_rise;
   logic sys_rise;
   logic external_prim;
   logic setup_ph;
   logic wr_acc;
   logic mapped;
   logic [31:0] rd_word;

   assign kind = prim_kind(st_reg.fosc); // R15
   assign external_prim = kind != KIND_INT;
   assign hf_rise = high_freq_internal_osc && !st_reg.hf_prev;
   assign lf_rise = low_freq_internal_osc && !st_reg.lf_prev;
   assign prim_rise = prim_osc_in && !st_reg.prim_prev;
   assign sys_rise = sw_if.clk_level && !st_reg.sys_prev;

   // Postscaler taps; combinational from the field so a change shows at once
   always_comb begin
      case (st_reg.ifs) // R18
         3'h7: int_level = st_reg.hf_prev;
         3'h6: int_level = st_reg.hf_cnt[0];
         3'h5: int_level = st_reg.hf_cnt[1];
         3'h4: int_level = st_reg.hf_cnt[2];
         3'h3: int_level = st_reg.hf_cnt[3];
         3'h2: int_level = st_reg.hf_cnt[4];
         3'h1: int_level = st_reg.hf_cnt[5];
         default: begin
            // Code 000 picks the 31.25 kHz reference
            int_level = st_reg.lfss ? st_reg.hf_cnt[`DIV512_BIT] // R19
               : low_freq_internal_osc; // R7
         end
      endcase
   end

   // Source levels and select request; a clock failure overrides software
   assign sw_if.src_prim = prim_osc_in && !st_reg.fail; // R13
   assign sw_if.src_sec = sec_osc_in;
   assign sw_if.src_int = int_level; // R5
   assign sw_if.req_sel = st_reg.fail ? 2'h2 : st_reg.system_clock_select; // R13

   clock_switcher u_switch (
      .pclk(pclk),
      .presetn(presetn),
      .sw(sw_if.sw)
   );

   // PLL multiplier only for high-speed external clock or HS crystal
   always_comb begin
      pll_mode = PLL_OFF; // R11
      if (sw_if.active_sel == 2'h0) begin
         if ((st_reg.fosc == 4'h4 || st_reg.fosc == 4'h5) &&
               st_reg.cfg_pll_en) begin
            pll_mode = st_reg.pll_mult_sel ? PLL_X3 : PLL_X4; // R10
         end else if (st_reg.fosc == 4'h2 && st_reg.spll_en) begin
            pll_mode = st_reg.spll_mult ? PLL_X3 : PLL_X4; // R10
         end
      end
   end

   // APB decode; zero wait states, unmapped offsets answer with an error
   assign setup_ph = psel && !penable;
   assign wr_acc = psel && penable && pwrite && mapped;
   assign mapped = paddr == `OFS_OSC_CONTROL ||
      paddr == `OFS_OSC_CONTROL_TWO || paddr == `OFS_CLOCK_CONFIG;

   // Read view of the three registers
   always_comb begin
      rd_word = 32'h0000_0000;
      case (paddr)
         `OFS_OSC_CONTROL: begin // R16
            rd_word[`POS_IDLE_EN] = st_reg.idle_en;
            rd_word[`POS_IFS_LO +: 3] = st_reg.ifs;
            rd_word[`POS_RUN_PRIMARY] = sw_if.active_sel == 2'h0;
            rd_word[`POS_HF_STABLE] = hf_stable;
            rd_word[`POS_SCS_LO +: 2] = st_reg.system_clock_select;
         end
         `OFS_OSC_CONTROL_TWO: begin // R16
            rd_word[`POS_PLL_RUN] = pll_mode != PLL_OFF;
            rd_word[`POS_SEC_RUN] = sw_if.active_sel == 2'h1;
            rd_word[`POS_LFSS] = st_reg.lfss;
            rd_word[`POS_SPLL_EN] = st_reg.spll_en;
            rd_word[`POS_PRI_DRIVE] = st_reg.pri_drive;
         end
         `OFS_CLOCK_CONFIG: begin
            rd_word[`POS_FOSC_LO +: 4] = st_reg.fosc;
            rd_word[`POS_CFG_PLL_EN] = st_reg.cfg_pll_en;
            rd_word[`POS_PLL_MULT_SEL] = st_reg.pll_mult_sel;
            rd_word[`POS_SPLL_MULT] = st_reg.spll_mult;
            rd_word[`POS_FAIL] = st_reg.fail;
         end
         default: rd_word = 32'h0000_0000;
      endcase
   end

   // Next state of every register of the block
   always_comb begin
      st_next = st_reg;
      st_next.hf_prev = high_freq_internal_osc;
      st_next.lf_prev = low_freq_internal_osc;
      st_next.prim_prev = prim_osc_in;
      st_next.sys_prev = sw_if.clk_level;
      st_next.idle_p = 1'b0;
      st_next.sleep_p = 1'b0;
      st_next.wdt_tick = lf_rise; // R8
      if (hf_rise) begin
         st_next.hf_cnt = st_reg.hf_cnt + 9'h001;
      end
      // Quarter-rate clock output follows system clock rising edges
      if (sys_rise) begin
         st_next.div4 = st_reg.div4 + 2'h1;
         if (st_reg.div4 == 2'h1 || st_reg.div4 == 2'h3) begin
            st_next.clk_out = !st_reg.clk_out; // R14
         end
      end
      // Register reads are captured in the setup cycle
      if (setup_ph) begin
         st_next.rdata = pwrite ? 32'h0000_0000 : rd_word;
         st_next.slverr = !mapped;
      end
      // Writes honour byte lanes 0 and 1
      if (wr_acc && paddr == `OFS_OSC_CONTROL && pstrb[0]) begin
         st_next.idle_en = pwdata[`POS_IDLE_EN];
         st_next.ifs = pwdata[`POS_IFS_LO +: 3]; // R4
         st_next.system_clock_select = pwdata[`POS_SCS_LO +: 2]; // R1
      end
      if (wr_acc && paddr == `OFS_OSC_CONTROL_TWO && pstrb[0]) begin
         st_next.lfss = pwdata[`POS_LFSS];
         st_next.spll_en = pwdata[`POS_SPLL_EN];
         st_next.pri_drive = pwdata[`POS_PRI_DRIVE];
      end
      if (wr_acc && paddr == `OFS_CLOCK_CONFIG && pstrb[0]) begin
         st_next.fosc = pwdata[`POS_FOSC_LO +: 4];
         st_next.cfg_pll_en = pwdata[`POS_CFG_PLL_EN];
         st_next.pll_mult_sel = pwdata[`POS_PLL_MULT_SEL];
         st_next.spll_mult = pwdata[`POS_SPLL_MULT];
      end
      // Failure flag: write one to clear, a new failure wins over it
      if (wr_acc && paddr == `OFS_CLOCK_CONFIG && pstrb[1] &&
            pwdata[`POS_FAIL]) begin
         st_next.fail = 1'b0;
      end
      // Monitor runs on low-frequency edges only, never on the system clock
      if (prim_rise || !external_prim) begin
         st_next.fail_cnt = 4'h0;
      end else if (lf_rise) begin // R8
         if (st_reg.fail_cnt == 4'(FAIL_EDGES - 1)) begin
            st_next.fail = 1'b1; // R13
            st_next.fail_cnt = 4'h0;
         end else begin
            st_next.fail_cnt = st_reg.fail_cnt + 4'h1;
         end
      end
      if (sleep_cmd) begin
         st_next.idle_p = st_reg.idle_en; // R20
         st_next.sleep_p = !st_reg.idle_en; // R9
      end
   end

   // Every reset returns to the primary clock and 1 MHz internal output
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '0;
         st_reg.system_clock_select <= `RST_SCS; // R2
         st_reg.ifs <= `RST_IFS; // R6
         st_reg.pri_drive <= `RST_PRI_DRIVE;
         st_reg.fosc <= `RST_FOSC;
         // Oscillator edge detectors start high: a pin already high at release is no edge
         st_reg.hf_prev <= 1'b1;
         st_reg.lf_prev <= 1'b1;
         st_reg.prim_prev <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs
   assign prdata = st_reg.rdata;
   assign pready = 1'b1;
   assign pslverr = st_reg.slverr && psel && penable;
   assign enter_idle = st_reg.idle_p;
   assign enter_sleep = st_reg.sleep_p;
   assign sys_clk_level = sw_if.clk_level; // R17
   assign sys_source = sw_if.active_sel;
   assign wdt_tick = st_reg.wdt_tick;
   assign primary_drive_on = st_reg.pri_drive;
   assign clock_fail = st_reg.fail;
   assign shared_osc_pin_o = pin_is_clkout(st_reg.fosc) ? st_reg.clk_out
      : gpio_out; // R14
   assign shared_osc_pin_oe_n = 1'b0;

   a_reset_primary_sel: assert property ( // R2
      @(posedge pclk) $rose(presetn) |-> st_reg.system_clock_select == 2'h0 &&
      st_reg.ifs == 3'h3)
      else $error("reset did not restore primary select and 1 MHz");

   a_fail_forces_int: assert property ( // R13
      @(posedge pclk) disable iff (!presetn)
      $rose(st_reg.fail) |-> ##[1:600] sys_source == 2'h2)
      else $error("clock failure did not move to internal block");

   a_fail_needs_edges: assert property ( // R13
      @(posedge pclk) disable iff (!presetn)
      $rose(st_reg.fail) |-> $past(lf_rise) && external_prim)
      else $error("failure flagged without low-frequency edge");

   a_pll_off_other: assert property ( // R11
      @(posedge pclk) disable iff (!presetn)
      (st_reg.fosc != 4'h2 && st_reg.fosc[3:1] != 3'h2) ||
      (st_reg.fosc == 4'h2 && !st_reg.spll_en) |-> pll_mode == PLL_OFF)
      else $error("PLL active outside its configurations");

   a_pll_ec_mult: assert property ( // R10
      @(posedge pclk) disable iff (!presetn)
      (sys_source == 2'h0 && st_reg.fosc[3:1] == 3'h2 &&
      st_reg.cfg_pll_en) |->
      pll_mode == (st_reg.pll_mult_sel ? PLL_X3 : PLL_X4))
      else $error("wrong PLL multiplier for external clock");

   a_low_ref_sel: assert property ( // R7
      @(posedge pclk) disable iff (!presetn)
      (st_reg.ifs == 3'h0 && !st_reg.lfss) |->
      sw_if.src_int == low_freq_internal_osc)
      else $error("code 000 did not use low oscillator");

   a_sleep_kind: assert property ( // R20
      @(posedge pclk) disable iff (!presetn)
      sleep_cmd |=> (enter_idle == $past(st_reg.idle_en)) &&
      (enter_sleep != enter_idle))
      else $error("sleep command entered the wrong mode");

   a_wdt_tick_src: assert property ( // R8
      @(posedge pclk) disable iff (!presetn)
      wdt_tick |-> $past(low_freq_internal_osc, 1) &&
      !$past(low_freq_internal_osc, 2))
      else $error("watchdog tick not from low oscillator edge");

   a_select_write: assert property ( // R3
      @(posedge pclk) disable iff (!presetn)
      (wr_acc && paddr == 12'h000 && pstrb[0] && !st_reg.fail) |=>
      sw_if.req_sel == $past(pwdata[1:0]))
      else $error("select write not forwarded to switcher");

   a_pll_primary_only: assert property ( // R10
      @(posedge pclk) disable iff (!presetn)
      sys_source != 2'h0 |-> pll_mode == PLL_OFF)
      else $error("PLL active while primary not running");

   a_fail_overrides: assert property ( // R13
      @(posedge pclk) disable iff (!presetn)
      st_reg.fail |-> sw_if.req_sel == 2'h2)
      else $error("clock failure did not request internal block");

   a_full_rate_tap: assert property ( // R18
      @(posedge pclk) disable iff (!presetn)
      st_reg.ifs == 3'h7 |-> sw_if.src_int == $past(high_freq_internal_osc))
      else $error("code 111 not the high oscillator level");

   a_div512_tap: assert property ( // R19
      @(posedge pclk) disable iff (!presetn)
      (st_reg.ifs == 3'h0 && st_reg.lfss) |->
      sw_if.src_int == st_reg.hf_cnt[`DIV512_BIT])
      else $error("code 000 with low select 1 not divided by 512");

   a_pin_io_mode: assert property ( // R14
      @(posedge pclk) disable iff (!presetn)
      !pin_is_clkout(st_reg.fosc) |-> shared_osc_pin_o == gpio_out)
      else $error("shared pin not in I/O mode for its code");

   c_fail_event: cover property (
      @(posedge pclk) disable iff (!presetn) $rose(st_reg.fail));
   c_secondary_run: cover property (
      @(posedge pclk) disable iff (!presetn) sys_source == 2'h1);
   c_pll_x3: cover property (
      @(posedge pclk) disable iff (!presetn) pll_mode == PLL_X3);
   c_idle_entry: cover property (
      @(posedge pclk) disable iff (!presetn) enter_idle);
endmodule

// ---- tb/system_clock_selector_tb.sv ----
`timescale 1ns/1ps
`include "clock_select_consts.svh"
module system_clock_selector_tb;
   import clock_select_pkg::*;
   // Bench drive
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, sleep_cmd = 1'b0, hf_stable = 1'b0, gpio_out = 1'b0;
   logic prim = 1'b0, sec = 1'b0, hf = 1'b0, lf = 1'b0, prim_run = 1'b1;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'h3;
   // Design outputs
   logic [31:0] prdata;
   logic pready, pslverr, enter_idle, enter_sleep, sys_clk_level, wdt_tick;
   logic primary_drive_on, clock_fail, pin_o, pin_oe_n;
   logic [1:0] sys_source;
   pll_mode_t pll_mode;
   // Bookkeeping
   logic [7:0] rnd = 8'h37;
   logic hs;
   logic [32:0] rd_q[$];
   logic [1:0] sl_q[$];
   logic [32:0] e_rd;
   logic [1:0] e_sl;
   int failures = 0, checked = 0, cyc = 0, n, k;
   logic [7:0] t8[8] = '{8'h34, 8'h14, 8'h55, 8'h42, 8'h02, 8'h42,
      8'h24, 8'h78};
   logic [7:0] t4[8] = '{8'h04, 8'h04, 8'h04, 8'h14, 8'h14, 8'h04,
      8'h04, 8'h14};
   logic [1:0] tm[8] = '{PLL_X3, PLL_X4, PLL_X4, PLL_X3, PLL_X4, PLL_OFF,
      PLL_OFF, PLL_OFF};
   int fcode[4] = '{7, 6, 5, 4};
   int fexp[4] = '{32, 16, 8, 4};

   always #2 pclk = ~pclk;

   system_clock_selector #(.FAIL_EDGES(2)) dut_u (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .prim_osc_in(prim),
      .sec_osc_in(sec), .high_freq_internal_osc(hf),
      .low_freq_internal_osc(lf), .hf_stable(hf_stable),
      .sleep_cmd(sleep_cmd), .enter_idle(enter_idle),
      .enter_sleep(enter_sleep), .sys_clk_level(sys_clk_level),
      .sys_source(sys_source), .pll_mode(pll_mode), .wdt_tick(wdt_tick),
      .primary_drive_on(primary_drive_on), .clock_fail(clock_fail),
      .gpio_out(gpio_out), .shared_osc_pin_o(pin_o),
      .shared_osc_pin_oe_n(pin_oe_n));

   function automatic logic [7:0] lfsr_next(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction

   // Oscillators well below pclk/2; primary can be stopped to fake a loss
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      rnd <= lfsr_next(rnd);
      gpio_out <= rnd[0];
      if (prim_run && cyc % 3 == 0) prim <= ~prim;
      if (cyc % 5 == 0) sec <= ~sec;
      if (cyc % 2 == 0) hf <= ~hf;
      if (cyc % 16 == 0) lf <= ~lf;
   end

   task automatic cmp(input string what, input logic [31:0] exp,
         input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Edge counts drift by one with phase, so allow that slack
   task automatic cmp_near(input string what, input int exp, input int got);
      checked++;
      if (got < exp - 1 || got > exp + 1) begin
         failures++;
         $display("[ERR] %s expected %0d seen %0d", what, exp, got);
      end
   endtask

   task automatic print_verdict;
      if (rd_q.size() != 0 || sl_q.size() != 0) failures++;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic timeout(input string what);
      failures++;
      $display("[ERR] %s expected done seen timeout", what);
      print_verdict();
   endtask

   // One APB transfer; entered just after a rising edge
   task automatic apb(input logic wr, input logic [11:0] a,
         input logic [31:0] d, input logic [32:0] exp);
      int w;
      if (!wr) rd_q.push_back(exp);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      w = 0;
      do begin
         @(posedge pclk);
         w++;
      end while (pready !== 1'b1 && w < 50);
      if (w >= 50) timeout("pready");
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 33'h0);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] d,
         input logic err);
      apb(1'b0, a, 32'h0, {err, d});
   endtask

   task automatic wait_src(input logic [1:0] m, input logic [1:0] v);
      int w;
      w = 0;
      while ((sys_source & m) !== v && w < 400) begin
         @(posedge pclk);
         w++;
      end
      if (w >= 400) timeout("sys_source");
      cmp("sys_source", {30'h0, v}, {30'h0, sys_source & m});
      @(posedge pclk);
   endtask

   // Rising edges of 0 system clock, 1 shared pin, 2 watchdog tick
   task automatic count_edges(input int sel, input int cycles, output int c);
      logic prev, cur;
      c = 0;
      prev = 1'b1;
      repeat (cycles) begin
         @(negedge pclk);
         case (sel)
            0: cur = sys_clk_level;
            1: cur = pin_o;
            default: cur = wdt_tick;
         endcase
         if (cur === 1'b1 && prev !== 1'b1) c++;
         prev = cur;
      end
      @(posedge pclk);
   endtask

   // Result watcher: read data and power-mode pulses against queued notes
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         e_rd = rd_q.pop_front();
         cmp("prdata", e_rd[31:0], prdata);
         cmp("pslverr", {31'h0, e_rd[32]}, {31'h0, pslverr});
      end
      if (enter_idle === 1'b1 || enter_sleep === 1'b1) begin
         e_sl = sl_q.pop_front();
         cmp("sleep pulses", {30'h0, e_sl},
            {30'h0, enter_idle, enter_sleep});
      end
   end

   // Global guard against a hang anywhere
   initial begin
      repeat (60000) @(posedge pclk);
      timeout("run");
   end

   initial begin
      hs = rnd[2];
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      hf_stable <= hs;
      @(posedge pclk);
      rd(`OFS_OSC_CONTROL, 32'h38 | (hs << 2), 1'b0);
      rd(`OFS_OSC_CONTROL_TWO, 32'h04, 1'b0);
      rd(`OFS_CLOCK_CONFIG, 32'h02, 1'b0);
      rd(12'h00C, 32'h0, 1'b1);
      $display("test reset values done");
      for (k = 0; k < 8; k++) begin
         wr(`OFS_OSC_CONTROL_TWO, {24'h0, t4[k]});
         wr(`OFS_CLOCK_CONFIG, {24'h0, t8[k]});
         @(negedge pclk);
         cmp("pll_mode", {30'h0, tm[k]}, {30'h0, pll_mode});
         @(posedge pclk);
         rd(`OFS_OSC_CONTROL_TWO, {24'h0, t4[k]} |
            ((tm[k] != PLL_OFF) << 7), 1'b0);
      end
      wr(`OFS_OSC_CONTROL_TWO, 32'h00);
      cmp("primary_drive_on", 32'h0, {31'h0, primary_drive_on});
      wr(`OFS_OSC_CONTROL_TWO, 32'h04);
      $display("test pll select done");
      wr(`OFS_CLOCK_CONFIG, 32'h06);
      count_edges(1, 192, n);
      cmp_near("clkout edges", 8, n);
      wr(`OFS_CLOCK_CONFIG, 32'h07);
      repeat (4) begin
         @(negedge pclk);
         cmp("shared pin", {31'h0, gpio_out}, {31'h0, pin_o});
         cmp("pin_oe_n", 32'h0, {31'h0, pin_oe_n});
      end
      @(posedge pclk);
      $display("test shared pin done");
      wr(`OFS_OSC_CONTROL, 32'h31);
      wait_src(2'b11, 2'b01);
      rd(`OFS_OSC_CONTROL_TWO, 32'h44, 1'b0);
      rd(`OFS_OSC_CONTROL, 32'h31 | (hs << 2), 1'b0);
      wr(`OFS_OSC_CONTROL, 32'h33);
      wait_src(2'b10, 2'b10);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      @(negedge pclk);
      cmp("sys_source in reset", 32'h0, {30'h0, sys_source});
      @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(`OFS_OSC_CONTROL, 32'h38 | (hs << 2), 1'b0);
      $display("test source switch done");
      wr(`OFS_OSC_CONTROL, 32'h32);
      wait_src(2'b10, 2'b10);
      count_edges(0, 128, n);
      cmp_near("1 MHz edges", 2, n);
      for (k = 0; k < 4; k++) begin
         wr(`OFS_OSC_CONTROL, (fcode[k] << 4) | 32'h02);
         count_edges(0, 128, n);
         cmp_near("internal edges", fexp[k], n);
      end
      wr(`OFS_OSC_CONTROL, 32'h02);
      count_edges(0, 128, n);
      cmp_near("low osc edges", 4, n);
      wr(`OFS_OSC_CONTROL_TWO, 32'h24);
      count_edges(0, 128, n);
      cmp_near("hf div512 edges", 0, n);
      count_edges(2, 256, n);
      cmp_near("watchdog ticks", 8, n);
      $display("test internal block done");
      for (k = 0; k < 2; k++) begin
         wr(`OFS_OSC_CONTROL, 32'h02 | (k << 7));
         sl_q.push_back(k ? 2'b10 : 2'b01);
         sleep_cmd <= 1'b1;
         @(posedge pclk);
         sleep_cmd <= 1'b0;
         repeat (3) @(posedge pclk);
      end
      $display("test sleep done");
      wr(`OFS_OSC_CONTROL, 32'h30);
      wait_src(2'b11, 2'b00);
      prim_run <= 1'b0;
      n = 0;
      while (clock_fail !== 1'b1 && n < 400) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 400) timeout("clock_fail");
      wait_src(2'b10, 2'b10);
      rd(`OFS_CLOCK_CONFIG, 32'h102, 1'b0);
      prim_run <= 1'b1;
      wr(`OFS_CLOCK_CONFIG, 32'h102);
      repeat (2) @(posedge pclk);
      cmp("clock_fail", 32'h0, {31'h0, clock_fail});
      wait_src(2'b11, 2'b00);
      $display("test fail monitor done");
      print_verdict();
   end
endmodule
